/* nft_pkg.sv */
// nft_pkg: constants shared by the nor flash timing engine
// assumes: one functional clock at 100 MHz, timing points in ticks of time_scale+1 clock cycles, gap in clock cycles
package nft_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned NUM_SELECTS   = 4;
  localparam int unsigned NUM_WAITS     = 2;
  localparam int unsigned FIELD_W       = 5;
  localparam int unsigned SCALE_W       = 2;
  localparam int unsigned DIV_W         = 2;
  localparam int unsigned BURST_W       = 4;
  localparam int unsigned ADDR_W        = 27;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned CNT_W         = 12;
  localparam int unsigned SCALE_CNT_W   = 3;
  // values after reset
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 27'h0000000;
  localparam logic [CNT_W-1:0]  CNT_RST  = 12'h000;

  typedef enum logic [4:0] {
    NFT_IDLE   = 5'b00001,
    NFT_LEAD   = 5'b00010,
    NFT_ACCESS = 5'b00100,
    NFT_PAGE   = 5'b01000,
    NFT_GAP    = 5'b10000
  } nft_state_type;
endpackage : nft_pkg

/* nft_half_shift.sv */
// nft_half_shift: delays a strobe level by half a functional clock when asked
// assumes: level comes from a flop on the rising edge of the same clock
module nft_half_shift (
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  input  wire logic level_in,
  input  wire logic shift_in,
  output logic      level_out
);
  logic fall_reg;

  // falling edge copy gives the half cycle shift
  always_ff @(negedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fall_reg <= 1'b1;
    end else begin
      fall_reg <= level_in;
    end
  end

  assign level_out = shift_in ? fall_reg : level_in;
endmodule : nft_half_shift

/* nft_timing_engine.sv */
// nft_timing_engine: asynchronous nor flash access timing engine
// assumes: request is held stable with its fields until accepted on a
// rising edge with ready high; the flash is asynchronous; wait pins are
// only passed through synchronisers for the controller around it.

module nft_timing_engine #(
  parameter int unsigned FW = nft_pkg::FIELD_W,
  parameter int unsigned BW = nft_pkg::BURST_W
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_in,
  // request side
  input  wire logic                          req_valid_in,
  input  wire logic                          req_write_in,
  input  wire logic [1:0]                    req_select_in,
  input  wire logic [BW-1:0]                 req_count_in,
  input  wire logic [nft_pkg::ADDR_W-1:0]    req_addr_in,
  input  wire logic [1:0]                    req_byte_en_in,
  input  wire logic [nft_pkg::DATA_W-1:0]    req_wdata_in,
  output logic                               req_ready_out,
  // timing set of the requested select
  input  wire logic [FW-1:0]                 select_assert_point_in,
  input  wire logic [FW-1:0]                 select_read_off_point_in,
  input  wire logic [FW-1:0]                 select_write_off_point_in,
  input  wire logic [FW-1:0]                 addr_valid_on_point_in,
  input  wire logic [FW-1:0]                 addr_valid_read_off_in,
  input  wire logic [FW-1:0]                 addr_valid_write_off_in,
  input  wire logic [FW-1:0]                 read_enable_on_point_in,
  input  wire logic [FW-1:0]                 read_enable_off_point_in,
  input  wire logic [FW-1:0]                 write_enable_on_point_in,
  input  wire logic [FW-1:0]                 write_enable_off_point_in,
  input  wire logic [FW-1:0]                 read_cycle_len_in,
  input  wire logic [FW-1:0]                 write_cycle_len_in,
  input  wire logic [FW-1:0]                 sample_delay_in,
  input  wire logic [FW-1:0]                 page_step_delay_in,
  input  wire logic [FW-1:0]                 gap_cycles_in,
  input  wire logic [nft_pkg::SCALE_W-1:0]   time_scale_in,
  input  wire logic [nft_pkg::DIV_W-1:0]     out_clock_divider_in,
  input  wire logic                          select_half_shift_in,
  input  wire logic                          addr_valid_half_shift_in,
  input  wire logic                          read_enable_half_shift_in,
  input  wire logic                          write_enable_half_shift_in,
  // read data return
  output logic [nft_pkg::DATA_W-1:0]         rdata_out,
  output logic                               rdata_valid_out,
  output logic                               busy_out,
  output logic [nft_pkg::NUM_WAITS-1:0]      mem_wait_sync_out,
  // memory pins
  output logic [nft_pkg::NUM_SELECTS-1:0]    mem_chip_select_n_out,
  output logic                               addr_valid_n_out,
  output logic                               read_enable_n_out,
  output logic                               write_enable_n_out,
  output logic                               byte_enable_low_n_out,
  output logic                               byte_enable_high_n_out,
  output logic [nft_pkg::ADDR_W-1:0]         mem_addr_out,
  output logic [nft_pkg::DATA_W-1:0]         mem_data_out,
  output logic                               mem_data_oe_out,
  input  wire logic [nft_pkg::DATA_W-1:0]    mem_data_in,
  input  wire logic [nft_pkg::NUM_WAITS-1:0] mem_wait_in,
  output logic                               mem_clock_out
);
  localparam int unsigned CW = nft_pkg::CNT_W;

  nft_pkg::nft_state_type state_reg;
  logic [CW-1:0]                  cnt_reg;       // scaled ticks since start
  logic [nft_pkg::SCALE_CNT_W-1:0] pre_reg;      // scale prescaler
  logic [CW-1:0]                  gap_reg;
  logic [CW-1:0]                  page_cnt_reg;  // unscaled page step counter
  logic [BW-1:0]                  words_reg;     // words still to sample
  logic [BW-1:0]                  count_reg;
  logic                           write_reg;
  logic [1:0]                     sel_reg;
  logic [1:0]                     be_reg;
  logic [nft_pkg::DATA_W-1:0]     rdata_reg;
  logic                           rvalid_reg;
  logic                           cs_lvl_reg;
  logic                           adv_lvl_reg;
  logic                           oe_lvl_reg;
  logic                           we_lvl_reg;
  logic [nft_pkg::NUM_WAITS-1:0]  wait_meta_reg;
  logic [nft_pkg::NUM_WAITS-1:0]  wait_sync_reg;
  logic [nft_pkg::DIV_W-1:0]      div_reg;
  logic                           mclk_reg;

  logic          tick;        // one scaled time unit passes
  logic [CW-1:0] extra;       // (n-1) page steps
  logic [CW-1:0] cs_off_pt;
  logic [CW-1:0] adv_off_pt;
  logic [CW-1:0] oe_off_pt;
  logic [CW-1:0] cyc_len;
  logic [CW-1:0] page_len;
  logic          cs_n;
  logic          adv_n;
  logic          oe_n;
  logic          we_n;
  logic          acc_next;    // access window still open after this edge
  logic [CW-1:0] cnt_next;    // scaled count after this edge
  logic          wr_now;      // direction of the access started or running
  logic          take_first;  // first read word sampled at this edge
  logic          take_next;   // later page word sampled at this edge

  assign tick     = (pre_reg == {1'b0, time_scale_in});
  assign extra    = CW'(count_reg) * CW'(page_step_delay_in);
  assign page_len = CW'(page_step_delay_in) * CW'({1'b0, time_scale_in} + 3'h1);
  // off points, select, read enable and cycle length with burst extension (address valid without), all from the common start
  assign cs_off_pt  = CW'(wr_now ? select_write_off_point_in
                                    : select_read_off_point_in) + extra;
  assign adv_off_pt = CW'(wr_now ? addr_valid_write_off_in
                                    : addr_valid_read_off_in);
  assign oe_off_pt  = CW'(read_enable_off_point_in) + extra;
  assign cyc_len    = CW'(write_reg ? write_cycle_len_in : read_cycle_len_in)
                      + extra;

  assign req_ready_out = (state_reg == nft_pkg::NFT_IDLE);
  assign busy_out      = !req_ready_out;

  // strobe levels follow the count after the edge, so every edge point
  // lines up with the address launched at the accepting edge
  always_comb begin
    acc_next = 1'b0;
    cnt_next = nft_pkg::CNT_RST;
    if (state_reg == nft_pkg::NFT_IDLE) begin
      acc_next = req_valid_in;
    end else if (state_reg == nft_pkg::NFT_ACCESS) begin
      acc_next = !(tick && (cnt_reg + 12'h001 >= cyc_len));
      cnt_next = tick ? cnt_reg + 12'h001 : cnt_reg;
    end
  end
  assign wr_now = (state_reg == nft_pkg::NFT_IDLE) ? req_write_in : write_reg;

  // access sequencer: idle, access window (page sampling inside it), gap
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= nft_pkg::NFT_IDLE;
      gap_reg   <= nft_pkg::CNT_RST;
    end else begin
      case (state_reg)
        nft_pkg::NFT_IDLE: begin
          if (req_valid_in) begin
            state_reg <= nft_pkg::NFT_ACCESS;
          end
        end
        nft_pkg::NFT_ACCESS: begin
          if (tick && (cnt_reg + 12'h001 >= cyc_len)) begin
            gap_reg   <= CW'(gap_cycles_in);
            state_reg <= nft_pkg::NFT_GAP;
          end
        end
        nft_pkg::NFT_GAP: begin
          if (gap_reg <= 12'h001) begin
            state_reg <= nft_pkg::NFT_IDLE;
          end else begin
            gap_reg <= gap_reg - 12'h001;
          end
        end
        default: begin
          state_reg <= nft_pkg::NFT_IDLE;
        end
      endcase
    end
  end

  // scaled time base: each tick is time_scale+1 functional clocks
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_reg <= '0;
      cnt_reg <= nft_pkg::CNT_RST;
    end else if (state_reg != nft_pkg::NFT_ACCESS) begin
      pre_reg <= '0;
      cnt_reg <= nft_pkg::CNT_RST;
    end else if (tick) begin
      pre_reg <= '0;
      cnt_reg <= cnt_reg + 12'h001;
    end else begin
      pre_reg <= pre_reg + 3'h1;
    end
  end

  // request capture: address, byte enables and write data valid at start
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      write_reg    <= 1'b0;
      sel_reg      <= 2'h0;
      be_reg       <= 2'h0;
      count_reg    <= '0;
      mem_data_out <= nft_pkg::DATA_RST;
    end else if (state_reg == nft_pkg::NFT_IDLE && req_valid_in) begin
      write_reg    <= req_write_in;
      sel_reg      <= req_select_in;
      be_reg       <= req_byte_en_in;
      count_reg    <= (req_count_in == '0) ? '0 : req_count_in - BW'(1);
      mem_data_out <= req_wdata_in;
    end
  end

  // page address stepping: each later phase lasts one page step
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mem_addr_out <= nft_pkg::ADDR_RST;
    end else if (state_reg == nft_pkg::NFT_IDLE && req_valid_in) begin
      mem_addr_out <= req_addr_in;
    end else if ((take_first || take_next) && words_reg > BW'(1)) begin
      mem_addr_out <= mem_addr_out + 27'h0000001;
    end
  end

  // sampling points: the address steps on the same edge, ahead of the next word
  assign take_first = (state_reg == nft_pkg::NFT_ACCESS) && !write_reg && tick
                      && (words_reg == req_count_in_w(count_reg))
                      && (cnt_reg + 12'h001 == CW'(sample_delay_in));
  assign take_next  = (state_reg == nft_pkg::NFT_ACCESS) && !write_reg
                      && (page_cnt_reg == 12'h001) && (words_reg != '0);

  // read sampling: first word at sample delay, then every page step
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      page_cnt_reg <= nft_pkg::CNT_RST;
      words_reg    <= '0;
      rdata_reg    <= nft_pkg::DATA_RST;
      rvalid_reg   <= 1'b0;
    end else begin
      rvalid_reg <= 1'b0;
      if (state_reg == nft_pkg::NFT_IDLE) begin
        page_cnt_reg <= nft_pkg::CNT_RST;
        words_reg    <= (req_count_in == '0) ? BW'(1) : req_count_in; // zero is single
      end else if (take_first) begin
        rdata_reg    <= mem_data_in;
        rvalid_reg   <= 1'b1;
        words_reg    <= words_reg - BW'(1);
        page_cnt_reg <= page_len;
      end else if (take_next) begin
        rdata_reg    <= mem_data_in;
        rvalid_reg   <= 1'b1;
        words_reg    <= words_reg - BW'(1);
        page_cnt_reg <= (words_reg == BW'(1)) ? nft_pkg::CNT_RST : page_len;
      end else if (state_reg == nft_pkg::NFT_ACCESS && page_cnt_reg > 12'h001) begin
        page_cnt_reg <= page_cnt_reg - 12'h001;
      end
    end
  end

  function automatic logic [BW-1:0] req_count_in_w(input logic [BW-1:0] c);
    req_count_in_w = c + BW'(1);
  endfunction : req_count_in_w

  // strobe levels on the rising edge, all counted from the common start
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cs_lvl_reg  <= 1'b0;
      adv_lvl_reg <= 1'b0;
      oe_lvl_reg  <= 1'b0;
      we_lvl_reg  <= 1'b0;
    end else if (!acc_next) begin
      cs_lvl_reg  <= 1'b0;
      adv_lvl_reg <= 1'b0;
      oe_lvl_reg  <= 1'b0;
      we_lvl_reg  <= 1'b0;
    end else begin
      cs_lvl_reg  <= (cnt_next >= CW'(select_assert_point_in))
                     && (cnt_next < cs_off_pt);
      adv_lvl_reg <= (cnt_next >= CW'(addr_valid_on_point_in))
                     && (cnt_next < adv_off_pt);
      oe_lvl_reg  <= !wr_now && (cnt_next >= CW'(read_enable_on_point_in))
                     && (cnt_next < oe_off_pt);
      we_lvl_reg  <= wr_now && (cnt_next >= CW'(write_enable_on_point_in))
                     && (cnt_next < CW'(write_enable_off_point_in));
    end
  end

  // half cycle shifts on the opposite clock edge
  nft_half_shift u_cs_shift (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .level_in(!cs_lvl_reg), .shift_in(select_half_shift_in), .level_out(cs_n));
  nft_half_shift u_adv_shift (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .level_in(!adv_lvl_reg), .shift_in(addr_valid_half_shift_in), .level_out(adv_n));
  nft_half_shift u_oe_shift (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .level_in(!oe_lvl_reg), .shift_in(read_enable_half_shift_in), .level_out(oe_n));
  nft_half_shift u_we_shift (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .level_in(!we_lvl_reg), .shift_in(write_enable_half_shift_in), .level_out(we_n));

  // one select per chip, the rest stay high
  genvar gi;
  generate
    for (gi = 0; gi < nft_pkg::NUM_SELECTS; gi++) begin : g_sel
      assign mem_chip_select_n_out[gi] = (sel_reg == 2'(gi)) ? cs_n : 1'b1;
    end
  endgenerate

  assign addr_valid_n_out       = adv_n;
  assign read_enable_n_out      = oe_n;
  assign write_enable_n_out     = we_n;
  // byte enables valid during the whole access window
  assign byte_enable_low_n_out  = !((state_reg == nft_pkg::NFT_ACCESS) && be_reg[0]);
  assign byte_enable_high_n_out = !((state_reg == nft_pkg::NFT_ACCESS) && be_reg[1]);
  assign mem_data_oe_out        = (state_reg == nft_pkg::NFT_ACCESS) && write_reg;
  assign rdata_out              = rdata_reg;
  assign rdata_valid_out        = rvalid_reg;

  // wait pins through two flops
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wait_meta_reg <= '0;
      wait_sync_reg <= '0;
    end else begin
      wait_meta_reg <= mem_wait_in;
      wait_sync_reg <= wait_meta_reg;
    end
  end
  assign mem_wait_sync_out = wait_sync_reg;

  // memory clock: divider zero runs at the functional clock rate
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_reg  <= '0;
      mclk_reg <= 1'b0;
    end else if (div_reg >= out_clock_divider_in) begin
      div_reg  <= '0;
      mclk_reg <= !mclk_reg;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign mem_clock_out = (out_clock_divider_in == '0) ? sys_clk_in : mclk_reg;
endmodule : nft_timing_engine

/* nft_flash_model.sv */
// nft_flash_model: asynchronous nor flash answering reads of the timing engine
// assumes: each word is a fixed pattern of its address, no wait states
module nft_flash_model (
  input  wire logic [3:0]  cs_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [26:0] addr_in,
  output logic      [15:0] data_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] word;
  // drive the word only while selected and read enabled, else its inverse
  always_comb begin
    word = addr_in[15:0] ^ 16'ha5c3;
    data_out = (!(&cs_n_in) && !oe_n_in) ? word : ~word;
  end
endmodule : nft_flash_model

/* nft_timing_engine_props.sv */
// nft_timing_engine_props: port checks of the nor flash timing engine
// assumes: bound into the engine, one clock, reset asynchronous active high
module nft_props (
  input wire logic       sys_clk_in,
  input wire logic       reset_in,
  input wire logic       req_valid_in,
  input wire logic       req_ready_out,
  input wire logic       busy_out,
  input wire logic       rdata_valid_out,
  input wire logic [3:0] mem_chip_select_n_out,
  input wire logic       read_enable_n_out,
  input wire logic       write_enable_n_out,
  input wire logic       mem_data_oe_out,
  input wire logic [1:0] mem_wait_in,
  input wire logic [1:0] mem_wait_sync_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] up_reg;
  // edges since reset release, so the synchroniser check skips its fill
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  a_gap_after_write: assert property ($fell(mem_data_oe_out) |-> busy_out)
    else $error("no gap after a write access");
  a_take_goes_busy: assert property (req_valid_in && req_ready_out |=> busy_out)
    else $error("accepted request left engine idle");
  a_idle_strobes_high: assert property (req_ready_out |->
    (&mem_chip_select_n_out) && read_enable_n_out && write_enable_n_out)
    else $error("strobe active while idle");
  a_one_select_low: assert property ($onehot0(~mem_chip_select_n_out))
    else $error("more than one select low");
  a_write_no_read: assert property (!write_enable_n_out |-> mem_data_oe_out && read_enable_n_out)
    else $error("write strobe outside a driven write");
  a_read_no_drive: assert property (!read_enable_n_out |-> !mem_data_oe_out)
    else $error("read strobe while driving data");
  a_sample_in_read: assert property (rdata_valid_out |-> busy_out && !mem_data_oe_out)
    else $error("read word outside a read access");
  a_wait_two_flops: assert property (up_reg == 2'h3 |->
    mem_wait_sync_out == $past(mem_wait_in, 2))
    else $error("wait synchroniser depth wrong");
  c_write: cover property (!write_enable_n_out);
  c_read: cover property (rdata_valid_out);
  c_take: cover property (req_valid_in && req_ready_out ##1 busy_out);
endmodule : nft_props

bind nft_timing_engine nft_props i_props (
  .sys_clk_in, .reset_in, .req_valid_in, .req_ready_out, .busy_out, .rdata_valid_out,
  .mem_chip_select_n_out, .read_enable_n_out, .write_enable_n_out, .mem_data_oe_out,
  .mem_wait_in, .mem_wait_sync_out
);

/* tb.sv */
// tb: directed checks of the nor flash timing engine against a flash model
// assumes: 100 MHz clock, inputs driven on the falling edge
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_in, reset_in, rv, rw, sh_cs, sh_adv, sh_oe, sh_we;
  logic        rdy, rval, busy, adv_n, oe_n, we_n, bel_n, beh_n, doe, mclk, bh;
  logic [1:0]  sel, scale, wt, wsync;
  logic [3:0]  cnt, cs_bus, csv;
  logic [4:0]  cson, csr, csw, advon, advr, advw, oeon, oeoff;
  logic [4:0]  weon, weoff, rcl, wcl, acc, pg, gap;
  logic [26:0] addr, maddr;
  logic [15:0] mdin, mdout, rdata, dv;
  logic [15:0] rq[$];
  time         rt[$];
  time         tcf, tcr, taf, tar, tof, tor, twf, twr, tbf, tbr;
  int          bad_count, samples_checked, cyc;
  wire         cs_n = cs_bus[sel];

  nft_timing_engine i_dut (
    .sys_clk_in, .reset_in, .req_valid_in(rv), .req_write_in(rw), .req_select_in(sel),
    .req_count_in(cnt), .req_addr_in(addr), .req_byte_en_in(2'h3),
    .req_wdata_in(~addr[15:0]), .req_ready_out(rdy), .select_assert_point_in(cson),
    .select_read_off_point_in(csr), .select_write_off_point_in(csw),
    .addr_valid_on_point_in(advon), .addr_valid_read_off_in(advr),
    .addr_valid_write_off_in(advw), .read_enable_on_point_in(oeon),
    .read_enable_off_point_in(oeoff), .write_enable_on_point_in(weon),
    .write_enable_off_point_in(weoff), .read_cycle_len_in(rcl), .write_cycle_len_in(wcl),
    .sample_delay_in(acc), .page_step_delay_in(pg), .gap_cycles_in(gap),
    .time_scale_in(scale), .out_clock_divider_in(2'h0), .select_half_shift_in(sh_cs),
    .addr_valid_half_shift_in(sh_adv), .read_enable_half_shift_in(sh_oe),
    .write_enable_half_shift_in(sh_we), .rdata_out(rdata), .rdata_valid_out(rval),
    .busy_out(busy), .mem_wait_sync_out(wsync), .mem_chip_select_n_out(cs_bus),
    .addr_valid_n_out(adv_n), .read_enable_n_out(oe_n), .write_enable_n_out(we_n),
    .byte_enable_low_n_out(bel_n), .byte_enable_high_n_out(beh_n), .mem_addr_out(maddr),
    .mem_data_out(mdout), .mem_data_oe_out(doe), .mem_data_in(mdin), .mem_wait_in(wt),
    .mem_clock_out(mclk)
  );
  nft_flash_model i_flash (.cs_n_in(cs_bus), .oe_n_in(oe_n), .addr_in(maddr), .data_out(mdin));

  // edge times of the strobes of the selected chip
  always @(negedge cs_n) tcf = $time;
  always @(posedge cs_n) tcr = $time;
  always @(negedge adv_n) taf = $time;
  always @(posedge adv_n) tar = $time;
  always @(negedge oe_n) tof = $time;
  always @(posedge oe_n) tor = $time;
  always @(negedge we_n) twf = $time;
  always @(posedge we_n) twr = $time;
  always @(negedge bel_n) tbf = $time;
  always @(posedge bel_n) tbr = $time;
  // select pattern and write data seen as the chip is selected
  always @(negedge cs_n) {bh, csv} = {beh_n, cs_bus};
  always @(negedge cs_n) dv = mdout;
  // read words and the times they were handed back
  always @(posedge sys_clk_in) if (rval === 1'b1) rq.push_back(rdata);
  always @(posedge sys_clk_in) if (rval === 1'b1) rt.push_back($time);
  // free running clock
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  // cycle ceiling that cuts a hung run short
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("BAD %0t seen %0d want %0d", $time, seen, want);
    end
  endtask : chk

  // expected time in ns for a point count and a half cycle count
  function automatic int ns(input int pts, input int half);
    return pts * (int'(scale) + 1) * 10 + 5 * half;
  endfunction : ns

  task automatic req(input logic w, input logic [1:0] s, input logic [3:0] n,
                     input logic [26:0] a);
    @(negedge sys_clk_in);
    {rv, rw, sel, cnt, addr} = {1'b1, w, s, n, a};
    @(posedge sys_clk_in);
    while (rdy !== 1'b1) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rv = 1'b0;
    @(posedge sys_clk_in);
    while (rdy !== 1'b1) @(posedge sys_clk_in);
  endtask : req

  task automatic meas(input logic w, input int n);
    int k;
    k = (n > 1) ? (n - 1) * int'(pg) : 0;
    chk(32'(tcr - tcf), ns((w ? csw : csr) - cson + k, 0));
    chk(32'(tcf - tbf), ns(cson, sh_cs));
    chk(32'(taf - tcf), ns(advon - cson, sh_adv - sh_cs));
    chk(32'(tar - tcf), ns((w ? advw : advr) - cson, sh_adv - sh_cs));
    chk(32'(tbr - tbf), ns((w ? wcl : rcl) + k, 0));
    chk({31'h0, bh}, 32'h0);
    if (w && n == 1) begin
      chk(32'(twf - tcf), ns(weon - cson, sh_we - sh_cs));
      chk(32'(twr - tcf), ns(weoff - cson, sh_we - sh_cs));
    end else if (!w) begin
      chk(32'(tof - tcf), ns(oeon - cson, sh_oe - sh_cs));
      chk(32'(tor - tcf), ns(oeoff - cson + k, sh_oe - sh_cs));
    end
  endtask : meas

  task automatic rdchk(input logic [26:0] a, input int n);
    chk(32'(rq.size()), 32'(n));
    if (rq.size() > 0) chk(32'(rt[0] - tbf), ns(acc, 2));
    for (int i = 0; i < n && i < rq.size(); i++) begin
      chk({16'h0, rq[i]}, {16'h0, (a[15:0] + 16'(i)) ^ 16'ha5c3});
      if (i > 0) chk(32'(rt[i] - rt[i - 1]), ns(pg, 0));
    end
    rq.delete();
    rt.delete();
  endtask : rdchk

  task automatic t_selects();
    for (int s = 0; s < 4; s++) begin
      req(1'b1, 2'(s), 4'h1, 27'(s * 16 + 5));
      meas(1'b1, 1);
      chk({28'h0, csv}, {28'h0, ~(4'h1 << s)});
      chk({16'h0, dv}, {16'h0, ~addr[15:0]});
    end
    $display("test selects done");
  endtask : t_selects

  task automatic t_scale_half();
    @(negedge sys_clk_in);
    scale = 2'h1;
    req(1'b0, 2'h2, 4'h1, 27'h81);
    meas(1'b0, 1);
    rdchk(27'h81, 1);
    @(negedge sys_clk_in);
    {scale, sh_cs, sh_adv, sh_oe, sh_we} = 6'h0a;
    req(1'b0, 2'h0, 4'h1, 27'h123);
    meas(1'b0, 1);
    rdchk(27'h123, 1);
    @(negedge sys_clk_in);
    {sh_cs, sh_adv, sh_oe, sh_we} = 4'h5;
    req(1'b1, 2'h3, 4'h1, 27'h7);
    meas(1'b1, 1);
    @(negedge sys_clk_in);
    {sh_cs, sh_adv, sh_oe, sh_we} = 4'h0;
    $display("test scale and half shift done");
  endtask : t_scale_half

  task automatic t_burst_gap();
    time t1;
    req(1'b0, 2'h1, 4'h4, 27'h200);
    meas(1'b0, 4);
    rdchk(27'h200, 4);
    req(1'b1, 2'h2, 4'h2, 27'h300);
    meas(1'b1, 2);
    @(negedge sys_clk_in);
    {scale, gap} = {2'h1, 5'h3};
    req(1'b1, 2'h0, 4'h1, 27'h10);
    t1 = tbr;
    req(1'b1, 2'h0, 4'h1, 27'h11);
    chk(32'(tbf - t1 >= 30 && tbf - t1 < 60), 32'h1);
    $display("test burst and gap done");
  endtask : t_burst_gap

  task automatic t_misc();
    time t0;
    @(negedge sys_clk_in);
    wt = 2'h2;
    repeat (3) @(negedge sys_clk_in);
    chk({30'h0, wsync}, 32'h2);
    @(posedge mclk);
    t0 = $time;
    @(posedge mclk);
    chk(32'($time - t0), 32'ha);
    $display("test wait and clock done");
  endtask : t_misc

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // reset, then the scenarios in turn
  initial begin
    {rv, rw, sel, cnt, addr, wt, scale} = '0;
    {sh_cs, sh_adv, sh_oe, sh_we} = 4'h0;
    {cson, csr, csw, advon} = {5'h2, 5'ha, 5'h8, 5'h2};
    {advr, advw, oeon, oeoff} = {5'h4, 5'h4, 5'h3, 5'h9};
    {weon, weoff, rcl, wcl, acc, pg, gap} = {5'h3, 5'h7, 5'hb, 5'h9, 5'h8, 5'h3, 5'h2};
    reset_in = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    reset_in = 1'b0;
    t_selects();
    t_scale_half();
    t_burst_gap();
    t_misc();
    print_verdict();
  end
endmodule : tb
